// ---- common/lbc_map.svh ----
// Purpose: offsets, reset values and timing for the lane B config slice
// Assumes: 125 MHz system clock
// Notes: constants only
`ifndef LBC_MAP_SVH
`define LBC_MAP_SVH
`define LBC_A_MON      8'h0A
`define LBC_A_DEEMPH   8'h11
`define LBC_A_THR      8'h12
`define LBC_A_SPARE0   8'h13
`define LBC_A_SPARE1   8'h14
`define LBC_A_PMODE    8'h15
`define LBC_A_EQ       8'h16
`define LBC_DEEMPH_RST 3'h2
`define LBC_THR_RST    4'h0
`define LBC_PMODE_RST  2'h0
`define LBC_EQ_RST     8'h2F
`define LBC_TERM_BIT   7
`define LBC_PROBE_MS   12
`define LBC_CLK_KHZ    125000
`define LBC_MAX_TRIES  50
`endif

// ---- common/lbc_pkg.sv ----
// Purpose: shared types for the lane B config slice
// Assumes: nothing
// Notes: mode codes follow the field encoding
package lbc_pkg;
	typedef enum logic [1:0] {LBC_PM_HIZ, LBC_PM_ONCE, LBC_PM_EVER, LBC_PM_TERM} lbc_pmode_t;
	typedef enum logic [3:0] {
		LBC_S_IDLE, LBC_S_ADDR, LBC_S_AACK, LBC_S_REG, LBC_S_RACK,
		LBC_S_WDAT, LBC_S_WACK, LBC_S_RDAT, LBC_S_MACK
	} lbc_smb_st_t;
endpackage

// ---- rtl/lbc_smbus_slave.sv ----
// Purpose: two-wire management slave with register pointer auto-increment
// Assumes: scl/sda already synchronous, slow against clk
// Notes: sda is open drain, oe high pulls low
`timescale 1ns/100ps
module lbc_smbus_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h58
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Register side
	output logic            wr_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	input  wire logic [7:0] rdata_i
);
	import lbc_pkg::*;
	lbc_smb_st_t st_q;
	logic [7:0] sh_q;
	logic [7:0] ptr_q;
	logic [3:0] cnt_q;
	logic       oe_q;
	logic       rd_q;
	logic       wr_q;
	logic       scl_q;
	logic       sda_q;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;

	assign rise  = scl_i & ~scl_q;
	assign fall  = ~scl_i & scl_q;
	assign start = scl_i & scl_q & sda_q & ~sda_i;
	assign stop  = scl_i & scl_q & ~sda_q & sda_i;
	assign sda_o    = 1'b0;
	assign sda_oe_o = oe_q;
	assign wr_o     = wr_q;
	assign addr_o   = ptr_q;
	assign wdata_o  = sh_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q  <= LBC_S_IDLE;
			sh_q  <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 4'h0;
			oe_q  <= 1'b0;
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (start) begin
				st_q  <= LBC_S_ADDR;
				cnt_q <= 4'h0;
				oe_q  <= 1'b0;
			end else if (stop) begin
				st_q <= LBC_S_IDLE;
				oe_q <= 1'b0;
			end else begin
				unique case (st_q)
					LBC_S_IDLE: begin
					end
					LBC_S_ADDR, LBC_S_REG, LBC_S_WDAT: begin
						if (rise) begin
							sh_q  <= {sh_q[6:0], sda_i};
							cnt_q <= cnt_q + 4'h1;
						end else if (fall && cnt_q == 4'h8) begin
							cnt_q <= 4'h0;
							oe_q  <= 1'b1;
							if (st_q == LBC_S_ADDR) begin
								rd_q <= sh_q[0];
								if (sh_q[7:1] == DEV_ADDR)
									st_q <= LBC_S_AACK;
								else begin
									oe_q <= 1'b0;
									st_q <= LBC_S_IDLE;
								end
							end else if (st_q == LBC_S_REG) begin
								ptr_q <= sh_q;
								st_q  <= LBC_S_RACK;
							end else begin
								wr_q <= 1'b1;
								st_q <= LBC_S_WACK;
							end
						end
					end
					LBC_S_AACK: begin
						if (fall) begin
							if (rd_q) begin
								sh_q <= rdata_i;
								oe_q <= ~rdata_i[7];
								st_q <= LBC_S_RDAT;
							end else begin
								oe_q <= 1'b0;
								st_q <= LBC_S_REG;
							end
						end
					end
					LBC_S_RACK, LBC_S_WACK: begin
						if (fall) begin
							oe_q <= 1'b0;
							st_q <= LBC_S_WDAT;
							if (st_q == LBC_S_WACK)
								ptr_q <= ptr_q + 8'h01;
						end
					end
					LBC_S_RDAT: begin
						if (fall) begin
							if (cnt_q == 4'h7) begin
								cnt_q <= 4'h0;
								oe_q  <= 1'b0;
								st_q  <= LBC_S_MACK;
							end else begin
								sh_q  <= {sh_q[6:0], 1'b0};
								oe_q  <= ~sh_q[6];
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					LBC_S_MACK: begin
						if (rise) begin
							if (sda_i)
								st_q <= LBC_S_IDLE;
							else
								ptr_q <= ptr_q + 8'h01;
						end else if (fall) begin
							sh_q <= rdata_i;
							oe_q <= ~rdata_i[7];
							st_q <= LBC_S_RDAT;
						end
					end
					default: st_q <= LBC_S_IDLE;
				endcase
			end
		end
	end

	property p_wr_ack;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_q |-> oe_q && st_q == LBC_S_WACK;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write strobe without ack");
endmodule

// ---- rtl/lbc_rx_probe.sv ----
// Purpose: far receiver probe timer and termination control for one lane
// Assumes: found_i is high while the probe sees a receiver
// Notes: a mode change restarts the search from scratch
`timescale 1ns/100ps
`include "lbc_map.svh"
module lbc_rx_probe #(
	parameter int unsigned PROBE_CYC = `LBC_PROBE_MS * `LBC_CLK_KHZ,
	parameter int unsigned MAX_TRIES = `LBC_MAX_TRIES
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	// Control
	input  wire lbc_pkg::lbc_pmode_t mode_i,
	input  wire logic               found_i,
	// Lane side
	output logic                    probe_o,
	output logic                    term_o
);
	import lbc_pkg::*;
	lbc_pmode_t  mode_q;
	logic [31:0] tmr_q;
	logic [15:0] tries_q;
	logic        det_q;
	logic        probe_q;
	logic        autom;
	logic        active;

	if (PROBE_CYC < 2 || MAX_TRIES < 1 || MAX_TRIES > 65535) begin : g_chk
		$error("lbc_rx_probe: bad parameters");
	end

	assign autom  = (mode_i == LBC_PM_ONCE) || (mode_i == LBC_PM_EVER);
	// Mode 01 gives up after the try budget, mode 10 never does
	assign active = autom && !det_q && mode_q == mode_i &&
		(mode_i == LBC_PM_EVER || tries_q < 16'(MAX_TRIES));
	assign probe_o = probe_q;
	assign term_o  = (mode_i == LBC_PM_TERM) || (autom && det_q);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q  <= LBC_PM_HIZ;
			tmr_q   <= 32'h0;
			tries_q <= 16'h0;
			det_q   <= 1'b0;
			probe_q <= 1'b0;
		end else begin
			mode_q  <= mode_i;
			probe_q <= 1'b0;
			if (mode_q != mode_i) begin
				tmr_q   <= 32'h0;
				tries_q <= 16'h0;
				det_q   <= 1'b0;
			end else if (active) begin
				if (found_i)
					det_q <= 1'b1;
				if (tmr_q == PROBE_CYC - 1) begin
					tmr_q   <= 32'h0;
					tries_q <= tries_q + 16'h1;
					probe_q <= 1'b1;
				end else
					tmr_q <= tmr_q + 32'h1;
			end
		end
	end

	property p_hiz;
		@(posedge clk_i) disable iff (!rst_n_i)
		mode_i == LBC_PM_HIZ |-> !term_o;
	endproperty
	a_hiz: assert property (p_hiz) else $error("hiz mode terminated");

	property p_open_until_found;
		@(posedge clk_i) disable iff (!rst_n_i)
		autom && !det_q |-> !term_o;
	endproperty
	a_open_until_found: assert property (p_open_until_found) else $error("early term");

	property p_budget;
		@(posedge clk_i) disable iff (!rst_n_i)
		mode_i == LBC_PM_ONCE && tries_q == 16'(MAX_TRIES) |=> !probe_q;
	endproperty
	a_budget: assert property (p_budget) else $error("probe past budget");

	property p_spacing;
		@(posedge clk_i) disable iff (!rst_n_i)
		probe_q |=> !probe_q;
	endproperty
	a_spacing: assert property (p_spacing) else $error("probes too close");
endmodule

// ---- rtl/lbc_lane_b_cfg.sv ----
// Purpose: lane 0/1 B-side config registers behind the management bus and EEPROM loader
// Assumes: global override bits and pin straps arrive as inputs
// Notes: reserved bits and bytes read zero and are not stored
`timescale 1ns/100ps
`include "lbc_map.svh"
module lbc_lane_b_cfg #(
	parameter logic [6:0]  DEV_ADDR  = 7'h58,
	parameter int unsigned PROBE_CYC = `LBC_PROBE_MS * `LBC_CLK_KHZ
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// Management bus
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// EEPROM loader
	input  wire logic       ee_wr_i,
	input  wire logic [7:0] ee_addr_i,
	input  wire logic [7:0] ee_data_i,
	// Global overrides and straps
	input  wire logic       ovr_presence_i,
	input  wire logic       ovr_probe_i,
	input  wire logic [1:0] pin_assert_thr_i,
	input  wire logic [1:0] pin_deassert_thr_i,
	input  wire logic [1:0] pin_probe_mode_i,
	// Lane status
	input  wire logic       lane0_term_i,
	input  wire logic [7:0] sig_present_i,
	input  wire logic       lane1_found_i,
	// Lane controls
	output logic [2:0]      lane0_deemph_o,
	output logic [1:0]      assert_thr_o,
	output logic [1:0]      deassert_thr_o,
	output logic [7:0]      lane1_eq_o,
	output logic            lane1_probe_o,
	output logic            lane1_term_o
);
	import lbc_pkg::*;
	logic       rst_q1;
	logic       rst_q2;
	logic       bus_wr;
	logic [7:0] bus_addr;
	logic [7:0] bus_wdata;
	logic       wr;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [2:0] deemph_q;
	logic [3:0] thr_q;
	logic [1:0] pmode_q;
	logic [7:0] eq_q;
	logic [1:0] asel_q;
	logic [1:0] dsel_q;
	lbc_pmode_t eff_mode;

	// Release reset through two flops so all state leaves reset on one edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end

	lbc_smbus_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_smb (
		.clk_i    (clk_sys_i),
		.rst_n_i  (rst_q2),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.sda_o    (sda_o),
		.sda_oe_o (sda_oe_o),
		.wr_o     (bus_wr),
		.addr_o   (bus_addr),
		.wdata_o  (bus_wdata),
		.rdata_i  (rdata)
	);

	// The loader only runs at power-up, so it simply wins a collision
	assign wr    = ee_wr_i | bus_wr;
	assign waddr = ee_wr_i ? ee_addr_i : bus_addr;
	assign wdata = ee_wr_i ? ee_data_i : bus_wdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// De-emphasis field; bit 7 is status, so only the low field stores
	always_ff @(posedge clk_sys_i or negedge rst_q2) begin
		if (!rst_q2)
			deemph_q <= `LBC_DEEMPH_RST;
		else if (wr && hit(waddr, `LBC_A_DEEMPH))
			deemph_q <= wdata[2:0];
	end

	always_ff @(posedge clk_sys_i or negedge rst_q2) begin
		if (!rst_q2)
			thr_q <= `LBC_THR_RST;
		else if (wr && hit(waddr, `LBC_A_THR))
			thr_q <= wdata[3:0];
	end

	always_ff @(posedge clk_sys_i or negedge rst_q2) begin
		if (!rst_q2)
			pmode_q <= `LBC_PMODE_RST;
		else if (wr && hit(waddr, `LBC_A_PMODE))
			pmode_q <= wdata[3:2];
	end

	always_ff @(posedge clk_sys_i or negedge rst_q2) begin
		if (!rst_q2)
			eq_q <= `LBC_EQ_RST;
		else if (wr && hit(waddr, `LBC_A_EQ))
			eq_q <= wdata;
	end

	// Threshold selection follows the override bit
	always_ff @(posedge clk_sys_i or negedge rst_q2) begin
		if (!rst_q2) begin
			asel_q <= 2'h0;
			dsel_q <= 2'h0;
		end else if (ovr_presence_i) begin
			asel_q <= thr_q[3:2];
			dsel_q <= thr_q[1:0];
		end else begin
			asel_q <= pin_assert_thr_i;
			dsel_q <= pin_deassert_thr_i;
		end
	end

	assign lane0_deemph_o = deemph_q;
	assign assert_thr_o   = asel_q;
	assign deassert_thr_o = dsel_q;
	assign lane1_eq_o     = eq_q;
	assign eff_mode = lbc_pmode_t'(ovr_probe_i ? pmode_q : pin_probe_mode_i);

	lbc_rx_probe #(
		.PROBE_CYC (PROBE_CYC),
		.MAX_TRIES (`LBC_MAX_TRIES)
	) u_probe1 (
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_q2),
		.mode_i  (eff_mode),
		.found_i (lane1_found_i),
		.probe_o (lane1_probe_o),
		.term_o  (lane1_term_o)
	);

	// Read mux; unmapped and reserved bytes read zero
	always_comb begin
		rdata = 8'h00;
		if (hit(bus_addr, `LBC_A_MON))
			rdata = ~sig_present_i;
		else if (hit(bus_addr, `LBC_A_DEEMPH)) begin
			rdata[2:0] = deemph_q;
			rdata[`LBC_TERM_BIT] = lane0_term_i;
		end else if (hit(bus_addr, `LBC_A_THR))
			rdata[3:0] = thr_q;
		else if (hit(bus_addr, `LBC_A_PMODE))
			rdata[3:2] = pmode_q;
		else if (hit(bus_addr, `LBC_A_EQ))
			rdata = eq_q;
	end

	property p_term_bit;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		hit(bus_addr, `LBC_A_DEEMPH) |-> rdata[`LBC_TERM_BIT] == lane0_term_i;
	endproperty
	a_term_bit: assert property (p_term_bit) else $error("status bit wrong");

	property p_deemph_wr;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		wr && hit(waddr, `LBC_A_DEEMPH) |=> lane0_deemph_o == $past(wdata[2:0]);
	endproperty
	a_deemph_wr: assert property (p_deemph_wr) else $error("deemph not written");

	property p_deemph_rst;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rst_q2 && !$past(rst_q2) |-> deemph_q == `LBC_DEEMPH_RST && eq_q == `LBC_EQ_RST;
	endproperty
	a_deemph_rst: assert property (p_deemph_rst) else $error("bad reset value");

	property p_thr_reg;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		ovr_presence_i |=> assert_thr_o == $past(thr_q[3:2])
			&& deassert_thr_o == $past(thr_q[1:0]);
	endproperty
	a_thr_reg: assert property (p_thr_reg) else $error("register thr not used");

	property p_thr_pin;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!ovr_presence_i |=> assert_thr_o == $past(pin_assert_thr_i)
			&& deassert_thr_o == $past(pin_deassert_thr_i);
	endproperty
	a_thr_pin: assert property (p_thr_pin) else $error("pin thr not used");

	property p_mode_src;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!ovr_probe_i && pin_probe_mode_i == 2'h3 |-> lane1_term_o;
	endproperty
	a_mode_src: assert property (p_mode_src) else $error("pin mode ignored");

	property p_mon;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		hit(bus_addr, `LBC_A_MON) |-> rdata == ~sig_present_i;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor polarity");

	property p_eq_wr;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		wr && hit(waddr, `LBC_A_EQ) |=> lane1_eq_o == $past(wdata);
	endproperty
	a_eq_wr: assert property (p_eq_wr) else $error("eq not written");

	property p_spare;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		hit(bus_addr, `LBC_A_SPARE0) || hit(bus_addr, `LBC_A_SPARE1) |-> rdata == 8'h00;
	endproperty
	a_spare: assert property (p_spare) else $error("spare not zero");

	// Fields move only on a write to their own byte, so refused bytes cannot leak in
	property p_deemph_hold;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!(wr && hit(waddr, `LBC_A_DEEMPH)) |=> $stable(deemph_q);
	endproperty
	a_deemph_hold: assert property (p_deemph_hold) else $error("deemph moved");

	property p_thr_hold;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!(wr && hit(waddr, `LBC_A_THR)) |=> $stable(thr_q);
	endproperty
	a_thr_hold: assert property (p_thr_hold) else $error("thresholds moved");

	property p_pmode_hold;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!(wr && hit(waddr, `LBC_A_PMODE)) |=> $stable(pmode_q);
	endproperty
	a_pmode_hold: assert property (p_pmode_hold) else $error("probe mode moved");

	property p_eq_hold;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!(wr && hit(waddr, `LBC_A_EQ)) |=> $stable(eq_q);
	endproperty
	a_eq_hold: assert property (p_eq_hold) else $error("eq moved");

	property p_thr_wr;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		wr && hit(waddr, `LBC_A_THR) |=> thr_q == $past(wdata[3:0]);
	endproperty
	a_thr_wr: assert property (p_thr_wr) else $error("thresholds not written");

	property p_pmode_wr;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		wr && hit(waddr, `LBC_A_PMODE) |=> pmode_q == $past(wdata[3:2]);
	endproperty
	a_pmode_wr: assert property (p_pmode_wr) else $error("probe mode not written");

	// Loader must land even when a bus write hits the same cycle
	property p_ee_deemph;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		ee_wr_i && hit(ee_addr_i, `LBC_A_DEEMPH) |=> deemph_q == $past(ee_data_i[2:0]);
	endproperty
	a_ee_deemph: assert property (p_ee_deemph) else $error("loader deemph lost");

	property p_ee_eq;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		ee_wr_i && hit(ee_addr_i, `LBC_A_EQ) |=> eq_q == $past(ee_data_i);
	endproperty
	a_ee_eq: assert property (p_ee_eq) else $error("loader eq lost");

	property p_pm_term;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		ovr_probe_i && pmode_q == LBC_PM_TERM |-> lane1_term_o;
	endproperty
	a_pm_term: assert property (p_pm_term) else $error("register term ignored");

	property p_pm_hiz;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		ovr_probe_i && pmode_q == LBC_PM_HIZ |-> !lane1_term_o;
	endproperty
	a_pm_hiz: assert property (p_pm_hiz) else $error("register hiz ignored");

	property p_pin_hiz;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		!ovr_probe_i && pin_probe_mode_i == LBC_PM_HIZ |-> !lane1_term_o;
	endproperty
	a_pin_hiz: assert property (p_pin_hiz) else $error("pin hiz ignored");

	property p_no_probe;
		@(posedge clk_sys_i) disable iff (!rst_q2)
		eff_mode == LBC_PM_HIZ || eff_mode == LBC_PM_TERM |=> !lane1_probe_o;
	endproperty
	a_no_probe: assert property (p_no_probe) else $error("probe in fixed mode");

	property p_thr_rst;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rst_q2 && !$past(rst_q2) |-> thr_q == `LBC_THR_RST && pmode_q == `LBC_PMODE_RST
			&& !lane1_probe_o;
	endproperty
	a_thr_rst: assert property (p_thr_rst) else $error("bad field reset");
endmodule

// ---- bench/lbc_host_model.sv ----
// Purpose: two-wire management host model for the lane B config slice
// Assumes: bus phases last a few system clocks, changes made at the falling clock edge
// Notes: open drain, pull_o high pulls sda low; a released line rises through the pull-up
`timescale 1ns/100ps
module lbc_host_model #(
	parameter logic [6:0] DEV = 7'h58
) (
	// Clock
	input  wire logic clk_i,
	// Bus
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      pull_o
);
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task automatic half(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Slow edges so the device's two-sample start filter always sees them
	task automatic pulse(output logic bit_o);
		half(3);
		scl_o = 1'b1;
		half(3);
		bit_o = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic start();
		half(1);
		pull_o = 1'b0;
		half(2);
		scl_o = 1'b1;
		half(3);
		pull_o = 1'b1;
		half(3);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		half(1);
		pull_o = 1'b1;
		half(2);
		scl_o = 1'b1;
		half(3);
		pull_o = 1'b0;
		half(3);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			half(1);
			pull_o = ~b[i];
			pulse(s);
		end
		half(1);
		pull_o = 1'b0;
		pulse(s);
		ack = ~s;
	endtask
	task automatic recv(input logic more, output logic [7:0] b);
		logic s;
		pull_o = 1'b0;
		for (int i = 7; i >= 0; i--) pulse(b[i]);
		half(1);
		pull_o = more;
		pulse(s);
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic a;
		start();
		send({DEV, 1'b0}, a);
		send(r, a);
		send(d, a);
		stop();
	endtask
	task automatic rd(input logic [7:0] r, input int n, output logic [31:0] q);
		logic       a;
		logic [7:0] b;
		q = '0;
		start();
		send({DEV, 1'b0}, a);
		send(r, a);
		start();
		send({DEV, 1'b1}, a);
		for (int i = n; i > 0; i--) begin
			recv(i > 1, b);
			q = {q[23:0], b};
		end
		stop();
	endtask
endmodule

// ---- bench/lbc_lane_b_cfg_test.sv ----
// Purpose: self-checking bench for the lane B config slice
// Assumes: probe period shortened to 20 clocks
// Notes: every value the host writes keeps reserved bits at zero unless a refusal is meant
`timescale 1ns/100ps
module lbc_lane_b_cfg_test;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        scl, pull, sda_oe, sda_o, sda_w;
	logic        ee_wr = 1'b0;
	logic [7:0]  ee_addr = 8'h00;
	logic [7:0]  ee_data = 8'h00;
	logic        ovr_pr = 1'b1;
	logic        ovr_pb = 1'b0;
	logic [1:0]  pin_a = 2'h0;
	logic [1:0]  pin_d = 2'h0;
	logic [1:0]  pin_m = 2'h0;
	logic        term0 = 1'b0;
	logic [7:0]  sig = 8'h00;
	logic        found = 1'b0;
	logic [2:0]  deemph;
	logic [1:0]  athr, dthr;
	logic [7:0]  eq;
	logic        probe, term1, ack;
	logic [31:0] q;
	int          err_count = 0;
	int          checks_done = 0;
	int          cnt;
	always #4 clk = ~clk;
	assign sda_w = ~((sda_oe & ~sda_o) | pull);
	lbc_host_model host_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .pull_o(pull));
	lbc_lane_b_cfg #(.PROBE_CYC(20)) dut_u (
		.clk_sys_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .ee_wr_i(ee_wr), .ee_addr_i(ee_addr), .ee_data_i(ee_data),
		.ovr_presence_i(ovr_pr), .ovr_probe_i(ovr_pb), .pin_assert_thr_i(pin_a),
		.pin_deassert_thr_i(pin_d), .pin_probe_mode_i(pin_m), .lane0_term_i(term0),
		.sig_present_i(sig), .lane1_found_i(found), .lane0_deemph_o(deemph),
		.assert_thr_o(athr), .deassert_thr_o(dthr), .lane1_eq_o(eq),
		.lane1_probe_o(probe), .lane1_term_o(term1));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset();
		chk(deemph, 3'h2);
		chk(eq, 8'h2F);
		chk({athr, dthr}, 4'h0);
		host_u.rd(8'h11, 4, q);
		chk(q, 32'h0200_0000);
		host_u.rd(8'h15, 2, q);
		chk(q, 32'h0000_002F);
	endtask
	task automatic t_deemph();
		for (int i = 0; i < 8; i++) begin
			term0 = i[0];
			host_u.wr(8'h11, {1'b1, 4'h0, i[2:0]});
			chk(deemph, i[2:0]);
			host_u.rd(8'h11, 1, q);
			chk(q, {24'h0, i[0], 4'h0, i[2:0]});
		end
	endtask
	task automatic t_thr();
		for (int i = 0; i < 16; i++) begin
			host_u.wr(8'h12, {4'h0, i[3:0]});
			chk({athr, dthr}, i[3:0]);
		end
		pin_a = 2'h1;
		pin_d = 2'h2;
		ovr_pr = 1'b0;
		repeat (3) @(negedge clk);
		chk({athr, dthr}, 4'h6);
	endtask
	task automatic t_mon();
		sig = 8'hA5;
		host_u.wr(8'h0A, 8'h00);
		host_u.rd(8'h0A, 1, q);
		chk(q, 32'h5A);
	endtask
	task automatic t_burst();
		host_u.start();
		host_u.send({7'h58, 1'b0}, ack);
		host_u.send(8'h15, ack);
		host_u.send(8'h04, ack);
		host_u.send(8'h55, ack);
		host_u.stop();
		chk(eq, 8'h55);
		host_u.rd(8'h15, 2, q);
		chk(q, 32'h0455);
		host_u.start();
		host_u.send({7'h2A, 1'b0}, ack);
		host_u.stop();
		chk(ack, 1'b0);
	endtask
	task automatic ee(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		ee_wr = 1'b1;
		ee_addr = a;
		ee_data = d;
		@(negedge clk);
		ee_wr = 1'b0;
	endtask
	task automatic t_ee();
		ee(8'h11, 8'h05);
		chk(deemph, 3'h5);
		ee(8'h16, 8'hA3);
		chk(eq, 8'hA3);
	endtask
	task automatic count(input logic [7:0] m);
		host_u.wr(8'h15, m);
		cnt = 0;
		repeat (1200) begin
			@(negedge clk);
			cnt += probe;
		end
	endtask
	task automatic t_probe();
		pin_m = 2'h3;
		repeat (3) @(negedge clk);
		chk(term1, 1'b1);
		ovr_pb = 1'b1;
		host_u.wr(8'h15, 8'h00);
		chk(term1, 1'b0);
		host_u.wr(8'h15, 8'h0C);
		chk(term1, 1'b1);
		count(8'h04);
		chk(cnt, 50);
		chk(term1, 1'b0);
		count(8'h08);
		chk(cnt > 50, 1'b1);
		chk(term1, 1'b0);
		found = 1'b1;
		@(negedge clk);
		found = 1'b0;
		repeat (2) @(negedge clk);
		chk(term1, 1'b1);
	endtask
	initial begin
		repeat (100000) @(negedge clk);
		err_count++;
		results();
	end
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_deemph();
		t_thr();
		t_mon();
		t_burst();
		t_ee();
		t_probe();
		results();
	end
endmodule
